// File: test/timer_pin_partner.sv
// Pin-side model that drives the external clock and capture pins
`timescale 1ns/1ps
module timer_pin_partner (
    input wire logic clk,
    output logic ext_clk,
    output logic cap_in
);
    // Pins stay routed to the timer for the whole run
    initial begin
        ext_clk = 1'b0;
        cap_in = 1'b0;
    end
    task automatic set_ext(input logic v);
        @(negedge clk);
        ext_clk = v;
    endtask : set_ext
    task automatic set_cap(input logic v);
        @(negedge clk);
        cap_in = v;
    endtask : set_cap
    // Covers the two-flop synchroniser delay
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask : settle
    task automatic pulse_ext(input int n);
        repeat (n) begin
            set_ext(1'b1);
            settle();
            set_ext(1'b0);
            settle();
        end
    endtask : pulse_ext
endmodule : timer_pin_partner

// File: test/timer_unit_tb.sv
// Self-checking bench for the timer unit core
`timescale 1ns/1ps
module timer_unit_tb import timer_pkg::*;;
    logic SYS_CLK, RESET_N, TIMER_ON, PAUSE, INIT_LEVEL, CLEAR_ON_A;
    logic HIGH_CLK_TICK, SUB_CLK_TICK, REG_WR, REG_RD, EXT_CLOCK_IN, CAPTURE_IN;
    logic [2:0] CLK_SEL, REG_SEL;
    logic [1:0] MODE, PIN_ACTION, CAPTURE_EDGE;
    logic [7:0] REG_WDATA, REG_RDATA;
    logic WAVE_OUT, WAVE_OUT_INV, INT_A, INT_P;
    int mismatches = 0;
    int total_checks = 0;

    timer_unit timer_unit_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TIMER_ON(TIMER_ON),
        .PAUSE(PAUSE), .CLK_SEL(CLK_SEL), .MODE(MODE), .PIN_ACTION(PIN_ACTION),
        .INIT_LEVEL(INIT_LEVEL), .CLEAR_ON_A(CLEAR_ON_A), .CAPTURE_EDGE(CAPTURE_EDGE),
        .HIGH_CLK_TICK(HIGH_CLK_TICK), .SUB_CLK_TICK(SUB_CLK_TICK),
        .EXT_CLOCK_IN(EXT_CLOCK_IN), .CAPTURE_IN(CAPTURE_IN), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .WAVE_OUT(WAVE_OUT), .WAVE_OUT_INV(WAVE_OUT_INV), .INT_A(INT_A), .INT_P(INT_P));
    timer_pin_partner timer_pin_partner_inst (.clk(SYS_CLK), .ext_clk(EXT_CLOCK_IN),
        .cap_in(CAPTURE_IN));

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    always @(negedge SYS_CLK) begin
        if (RESET_N === 1'b1) begin
            check("wave_pair", 16'(WAVE_OUT ^ WAVE_OUT_INV), 16'h0001);
        end
    end

    task automatic reg_write(input logic [2:0] sel, input logic [7:0] d);
        @(negedge SYS_CLK);
        REG_WR = 1'b1;
        REG_SEL = sel;
        REG_WDATA = d;
        @(negedge SYS_CLK);
        REG_WR = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [2:0] sel, output logic [7:0] d);
        @(negedge SYS_CLK);
        REG_RD = 1'b1;
        REG_SEL = sel;
        @(negedge SYS_CLK);
        REG_RD = 1'b0;
        d = REG_RDATA;
    endtask : reg_read

    // Low byte first, then high byte
    task automatic wr10(input logic [2:0] lo, input logic [9:0] v);
        reg_write(lo, v[7:0]);
        reg_write(lo + 3'h1, {6'h00, v[9:8]});
    endtask : wr10

    // High byte first, then low byte
    task automatic rd10(input logic [2:0] hi, output logic [9:0] v);
        logic [7:0] h, l;
        reg_read(hi, h);
        reg_read(hi - 3'h1, l);
        v = {h[1:0], l};
    endtask : rd10

    task automatic setup(input logic [1:0] m, input logic [1:0] act, input logic [2:0] ck,
        input logic clr, input logic init);
        @(negedge SYS_CLK);
        TIMER_ON = 1'b0;
        MODE = m;
        PIN_ACTION = act;
        CLK_SEL = ck;
        CLEAR_ON_A = clr;
        INIT_LEVEL = init;
        @(negedge SYS_CLK);
        TIMER_ON = 1'b1;
    endtask : setup

    task automatic wait_int(input logic use_p, output int n);
        n = 0;
        repeat (2000) begin
            @(negedge SYS_CLK);
            n++;
            if ((use_p ? INT_P : INT_A) === 1'b1) break;
        end
    endtask : wait_int

    task automatic watch_a(output logic s);
        s = 1'b0;
        repeat (8) begin
            @(negedge SYS_CLK);
            if (INT_A === 1'b1) s = 1'b1;
        end
    endtask : watch_a

    task automatic t_bytes();
        logic [9:0] v;
        logic [7:0] h;
        rd10(SEL_CNT_HI, v);
        check("count_idle", 16'(v), 16'h0000);
        wr10(SEL_A_LO, 10'h2a5);
        rd10(SEL_A_HI, v);
        check("a_value", 16'(v), 16'h02a5);
        reg_write(SEL_A_LO, 8'h3c);
        rd10(SEL_A_HI, v);
        check("a_low_kept", 16'(v), 16'h02a5);
        reg_read(SEL_A_HI, h);
        check("a_high_byte", 16'(h), 16'h0002);
        reg_read(3'h6, h);
        check("unmapped", 16'(h), 16'h0000);
    endtask : t_bytes

    task automatic t_compare();
        logic [1:0] acts [3] = '{ACT_TOGGLE, ACT_HIGH, ACT_LOW};
        logic inits [3] = '{1'b0, 1'b0, 1'b1};
        logic exps [3] = '{1'b1, 1'b1, 1'b0};
        int n;
        wr10(SEL_A_LO, 10'h005);
        for (int i = 0; i < 3; i++) begin
            setup(MODE_COMPARE, acts[i], CK_SYS, 1'b1, inits[i]);
            wait_int(1'b0, n);
            repeat (2) @(negedge SYS_CLK);
            check("wave_match", 16'(WAVE_OUT), 16'(exps[i]));
            wait_int(1'b0, n);
            check("a_period", 16'(n), 16'h0004);
        end
    endtask : t_compare

    task automatic t_period_p();
        int n;
        wr10(SEL_P_LO, 10'h003);
        setup(MODE_TIMER, ACT_NONE, CK_SYS, 1'b0, 1'b0);
        wait_int(1'b1, n);
        wait_int(1'b1, n);
        check("p_period", 16'(n), 16'h0004);
    endtask : t_period_p

    task automatic t_clock_src();
        logic [9:0] v;
        setup(MODE_TIMER, ACT_NONE, CK_EXT_FALL, 1'b1, 1'b0);
        timer_pin_partner_inst.set_ext(1'b1);
        timer_pin_partner_inst.settle();
        rd10(SEL_CNT_HI, v);
        check("rise_ignored", 16'(v), 16'h0000);
        timer_pin_partner_inst.set_ext(1'b0);
        timer_pin_partner_inst.settle();
        rd10(SEL_CNT_HI, v);
        check("fall_counted", 16'(v), 16'h0001);
        setup(MODE_TIMER, ACT_NONE, CK_H_DIV16, 1'b1, 1'b0);
        repeat (32) begin
            @(negedge SYS_CLK);
            HIGH_CLK_TICK = 1'b1;
            @(negedge SYS_CLK);
            HIGH_CLK_TICK = 1'b0;
        end
        rd10(SEL_CNT_HI, v);
        check("high_div16", 16'(v), 16'h0002);
        setup(MODE_TIMER, ACT_NONE, CK_SUB_A, 1'b1, 1'b0);
        repeat (3) begin
            @(negedge SYS_CLK);
            SUB_CLK_TICK = 1'b1;
            @(negedge SYS_CLK);
            SUB_CLK_TICK = 1'b0;
        end
        rd10(SEL_CNT_HI, v);
        check("sub_ticks", 16'(v), 16'h0003);
    endtask : t_clock_src

    task automatic t_capture();
        logic [9:0] v;
        logic s;
        setup(MODE_CAPTURE, ACT_NONE, CK_EXT_RISE, 1'b0, 1'b0);
        CAPTURE_EDGE = CAP_FALL;
        timer_pin_partner_inst.pulse_ext(3);
        rd10(SEL_CNT_HI, v);
        check("ext_rise_count", 16'(v), 16'h0003);
        timer_pin_partner_inst.set_cap(1'b1);
        watch_a(s);
        check("cap_rise_skip", 16'(s), 16'h0000);
        timer_pin_partner_inst.set_cap(1'b0);
        watch_a(s);
        check("cap_fall_int", 16'(s), 16'h0001);
        rd10(SEL_A_HI, v);
        check("cap_value", 16'(v), 16'h0003);
        CAPTURE_EDGE = CAP_BOTH;
        timer_pin_partner_inst.set_cap(1'b1);
        watch_a(s);
        check("cap_both_int", 16'(s), 16'h0001);
    endtask : t_capture

    task automatic t_pulse_pwm();
        int hi;
        wr10(SEL_P_LO, 10'h00f);
        wr10(SEL_A_LO, 10'h004);
        setup(MODE_PWM, PWM_ONE_SHOT, CK_SYS, 1'b0, 1'b0);
        timer_pin_partner_inst.settle();
        check("pulse_idle", 16'(WAVE_OUT), 16'h0000);
        timer_pin_partner_inst.set_ext(1'b1);
        hi = 0;
        repeat (20) @(negedge SYS_CLK) if (WAVE_OUT === 1'b1) hi++;
        check("pulse_width", 16'(hi), 16'h0005);
        check("pulse_end", 16'(WAVE_OUT), 16'h0000);
        timer_pin_partner_inst.set_ext(1'b0);
        setup(MODE_PWM, PWM_RUN, CK_SYS, 1'b0, 1'b0);
        repeat (40) @(negedge SYS_CLK);
        hi = 0;
        repeat (32) @(negedge SYS_CLK) if (WAVE_OUT === 1'b1) hi++;
        check("pwm_high", 16'(hi), 16'h0008);
    endtask : t_pulse_pwm

    // Sixteen unpaused system clocks give four ticks at any divider phase
    task automatic t_pause();
        logic [9:0] v;
        setup(MODE_TIMER, ACT_NONE, CK_SYS_DIV4, 1'b0, 1'b0);
        PAUSE = 1'b1;
        repeat (3) @(negedge SYS_CLK);
        PAUSE = 1'b0;
        repeat (16) @(negedge SYS_CLK);
        PAUSE = 1'b1;
        rd10(SEL_CNT_HI, v);
        check("pause_div4", 16'(v), 16'h0004);
        PAUSE = 1'b0;
    endtask : t_pause

    initial begin
        #1000000;
        mismatches++;
        complete_run();
    end

    initial begin
        {RESET_N, TIMER_ON, PAUSE, INIT_LEVEL, CLEAR_ON_A} = 5'h00;
        {HIGH_CLK_TICK, SUB_CLK_TICK, REG_WR, REG_RD} = 4'h0;
        {CLK_SEL, REG_SEL, MODE, PIN_ACTION, REG_WDATA} = 18'h00000;
        CAPTURE_EDGE = 2'h3;
        repeat (6) @(negedge SYS_CLK);
        check("wave_inv_reset", 16'(WAVE_OUT_INV), 16'h0001);
        RESET_N = 1'b1;
        t_bytes();
        t_compare();
        t_period_p();
        t_clock_src();
        t_capture();
        t_pulse_pwm();
        t_pause();
        complete_run();
    end
endmodule : timer_unit_tb

// File: verilog/timer_edge_sync.sv
// Shared timer constants and the pin synchroniser with edge detection
package timer_pkg;
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;
    // Byte register selects
    localparam logic [2:0] SEL_CNT_LO = 3'h0;
    localparam logic [2:0] SEL_CNT_HI = 3'h1;
    localparam logic [2:0] SEL_A_LO = 3'h2;
    localparam logic [2:0] SEL_A_HI = 3'h3;
    localparam logic [2:0] SEL_P_LO = 3'h4;
    localparam logic [2:0] SEL_P_HI = 3'h5;
    // Counter clock sources
    localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H_DIV16 = 3'h2;
    localparam logic [2:0] CK_H_DIV64 = 3'h3;
    localparam logic [2:0] CK_SUB_A = 3'h4;
    localparam logic [2:0] CK_SUB_B = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    // Operating modes
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } timer_mode_t;
    // Pin actions on compare match
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // PWM-mode pin actions
    localparam logic [1:0] PWM_FORCE_IDLE = 2'h0;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_RUN = 2'h2;
    localparam logic [1:0] PWM_ONE_SHOT = 2'h3;
    // Capture edges
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
endpackage : timer_pkg

`timescale 1ns/1ps
module timer_edge_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise = sync_reg && !last_reg;
    assign fall = !sync_reg && last_reg;
endmodule : timer_edge_sync

// File: verilog/timer_unit.sv
// Timer unit core: counter, two comparators, capture, pin waveforms, byte access
// How it works
// - A free-running up-counter is compared with the comparators and a match pulses an interrupt, may clear the counter and may change the pin.
// - CLK_SEL picks the counter tick from system clock fractions, the high clock, the sub clock or the external pin.
// - The external clock pin counts on its rising or falling edge as CLK_SEL chooses.
// - Comparator P pulses INT_P on a match; comparator A pulses INT_A on a match except in capture mode, where INT_A pulses on a capture.
// - In compare output mode a match drives the pins low, high or toggles them.
// - PWM appears on the same pin pair and the second pin is always the inverse of the first.
// - The capture input is taken on rising, falling or both edges as CAPTURE_EDGE chooses.
// - In single pulse mode an edge on the external clock pin launches the pulse.
// - Low bytes are only reached through one shared 8-bit buffer moved when the high byte is accessed.
// - A write to a compare low byte loads only the buffer.
// - A write to a compare high byte loads the high bits and copies the buffer into the low byte.
// - A read of a high byte returns it and copies the live low byte into the buffer.
// - A read of a low byte returns the buffer.
`timescale 1ns/1ps
module timer_unit
    import timer_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TIMER_ON,
    input wire logic PAUSE,
    input wire logic [2:0] CLK_SEL,
    input wire logic [1:0] MODE,
    input wire logic [1:0] PIN_ACTION,
    input wire logic INIT_LEVEL,
    input wire logic CLEAR_ON_A,
    input wire logic [1:0] CAPTURE_EDGE,
    input wire logic HIGH_CLK_TICK,
    input wire logic SUB_CLK_TICK,
    input wire logic EXT_CLOCK_IN,
    input wire logic CAPTURE_IN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [2:0] REG_SEL,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic WAVE_OUT,
    output logic WAVE_OUT_INV,
    output logic INT_A,
    output logic INT_P
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] compare_p_value;
    logic [7:0] buffer_reg;
    logic [1:0] div4_reg;
    logic [5:0] hdiv_reg;
    logic on_last_reg;
    logic one_shot_reg;
    logic wave_reg;
    logic ext_rise, ext_fall, cap_rise, cap_fall;
    logic tick, run, on_rise, a_match, p_match, clear_now, trigger, capture_now;
    logic [CNT_W-1:0] p_limit;
    timer_mode_t mode;

    assign mode = timer_mode_t'(MODE);

    timer_edge_sync ext_sync (
        .clk(SYS_CLK),
        .reset_n(RESET_N),
        .pin(EXT_CLOCK_IN),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    timer_edge_sync cap_sync (
        .clk(SYS_CLK),
        .reset_n(RESET_N),
        .pin(CAPTURE_IN),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    // Counter tick selection
    always_comb begin
        if (CLK_SEL == CK_SYS_DIV4) begin
            tick = (div4_reg == DIV4_LAST);
        end else if (CLK_SEL == CK_SYS) begin
            tick = 1'b1;
        end else if (CLK_SEL == CK_H_DIV16) begin
            tick = HIGH_CLK_TICK && (hdiv_reg[3:0] == DIV16_LAST);
        end else if (CLK_SEL == CK_H_DIV64) begin
            tick = HIGH_CLK_TICK && (hdiv_reg == DIV64_LAST);
        end else if (CLK_SEL == CK_SUB_A || CLK_SEL == CK_SUB_B) begin
            tick = SUB_CLK_TICK;
        end else if (CLK_SEL == CK_EXT_RISE) begin
            tick = ext_rise;
        end else begin
            tick = ext_fall;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div4_reg <= 2'h0;
            hdiv_reg <= 6'h00;
        end else begin
            div4_reg <= div4_reg + 2'h1;
            if (HIGH_CLK_TICK) begin
                hdiv_reg <= hdiv_reg + 6'h01;
            end
        end
    end

    // Comparator P of zero means a full 1024-tick period
    assign p_limit = (compare_p_value == CNT_ZERO) ? CNT_MAX : compare_p_value;
    assign a_match = (cnt_reg == compare_a_value);
    assign p_match = (cnt_reg == p_limit);
    assign on_rise = TIMER_ON && !on_last_reg;
    assign trigger = (CLK_SEL == CK_EXT_FALL) ? ext_fall : ext_rise;
    assign run = TIMER_ON && !PAUSE && !on_rise
        && (!(mode == MODE_PWM && PIN_ACTION == PWM_ONE_SHOT) || one_shot_reg);
    always_comb begin
        if (mode == MODE_COMPARE || mode == MODE_TIMER) begin
            clear_now = (CLEAR_ON_A ? a_match : p_match) || (cnt_reg == CNT_MAX);
        end else begin
            clear_now = p_match || (cnt_reg == CNT_MAX);
        end
    end
    always_comb begin
        if (CAPTURE_EDGE == CAP_RISE) begin
            capture_now = cap_rise;
        end else if (CAPTURE_EDGE == CAP_FALL) begin
            capture_now = cap_fall;
        end else if (CAPTURE_EDGE == CAP_BOTH) begin
            capture_now = cap_rise || cap_fall;
        end else begin
            capture_now = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            on_last_reg <= 1'b0;
        end else begin
            on_last_reg <= TIMER_ON;
        end
    end

    // Counter
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_reg <= CNT_ZERO;
        end else if (on_rise) begin
            cnt_reg <= CNT_ZERO;
        end else if (mode == MODE_PWM && PIN_ACTION == PWM_ONE_SHOT && !one_shot_reg
                     && TIMER_ON && trigger) begin
            cnt_reg <= CNT_ZERO;
        end else if (run && tick) begin
            cnt_reg <= clear_now ? CNT_ZERO : cnt_reg + CNT_ONE;
        end
    end

    // Match and capture interrupts
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            INT_A <= 1'b0;
            INT_P <= 1'b0;
        end else begin
            if (mode == MODE_CAPTURE) begin
                INT_A <= TIMER_ON && capture_now;
            end else begin
                INT_A <= run && tick && a_match;
            end
            INT_P <= run && tick && p_match;
        end
    end

    // Single pulse state
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            one_shot_reg <= 1'b0;
        end else if (!TIMER_ON || mode != MODE_PWM || PIN_ACTION != PWM_ONE_SHOT) begin
            one_shot_reg <= 1'b0;
        end else if (!one_shot_reg && trigger) begin
            one_shot_reg <= 1'b1;
        end else if (run && tick && a_match) begin
            one_shot_reg <= 1'b0;
        end
    end

    // Pin waveform
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wave_reg <= 1'b0;
        end else if (on_rise) begin
            wave_reg <= INIT_LEVEL;
        end else if (mode == MODE_COMPARE) begin
            if (run && tick && a_match) begin
                case (PIN_ACTION)
                    ACT_LOW: wave_reg <= 1'b0;
                    ACT_HIGH: wave_reg <= 1'b1;
                    ACT_TOGGLE: wave_reg <= !wave_reg;
                    default: wave_reg <= wave_reg;
                endcase
            end
        end else if (mode == MODE_PWM) begin
            case (PIN_ACTION)
                PWM_FORCE_IDLE: wave_reg <= INIT_LEVEL;
                PWM_FORCE_ACTIVE: wave_reg <= !INIT_LEVEL;
                PWM_RUN: wave_reg <= (cnt_reg < compare_a_value) ? !INIT_LEVEL : INIT_LEVEL;
                default: wave_reg <= one_shot_reg ? !INIT_LEVEL : INIT_LEVEL;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WAVE_OUT <= 1'b0;
            WAVE_OUT_INV <= 1'b1;
        end else begin
            WAVE_OUT <= wave_reg;
            WAVE_OUT_INV <= !wave_reg;
        end
    end

    // Comparator A: software writes or capture
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            compare_a_value <= CNT_ZERO;
        end else if (REG_WR && REG_SEL == SEL_A_HI) begin
            compare_a_value <= {REG_WDATA[1:0], buffer_reg};
        end else if (mode == MODE_CAPTURE && TIMER_ON && capture_now) begin
            compare_a_value <= cnt_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            compare_p_value <= CNT_ZERO;
        end else if (REG_WR && REG_SEL == SEL_P_HI) begin
            compare_p_value <= {REG_WDATA[1:0], buffer_reg};
        end
    end

    // Shared low-byte buffer
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            buffer_reg <= 8'h00;
        end else if (REG_WR && (REG_SEL == SEL_A_LO || REG_SEL == SEL_P_LO)) begin
            buffer_reg <= REG_WDATA;
        end else if (REG_RD && REG_SEL == SEL_CNT_HI) begin
            buffer_reg <= cnt_reg[7:0];
        end else if (REG_RD && REG_SEL == SEL_A_HI) begin
            buffer_reg <= compare_a_value[7:0];
        end else if (REG_RD && REG_SEL == SEL_P_HI) begin
            buffer_reg <= compare_p_value[7:0];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            if (REG_SEL == SEL_CNT_HI) begin
                REG_RDATA <= {6'h00, cnt_reg[9:8]};
            end else if (REG_SEL == SEL_A_HI) begin
                REG_RDATA <= {6'h00, compare_a_value[9:8]};
            end else if (REG_SEL == SEL_P_HI) begin
                REG_RDATA <= {6'h00, compare_p_value[9:8]};
            end else if (REG_SEL == SEL_CNT_LO || REG_SEL == SEL_A_LO || REG_SEL == SEL_P_LO) begin
                REG_RDATA <= buffer_reg;
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

    sequence hi_write_a_s;
        REG_WR && REG_SEL == SEL_A_HI;
    endsequence
    sequence hi_read_cnt_s;
        REG_RD && REG_SEL == SEL_CNT_HI;
    endsequence

    match_a_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (mode != MODE_CAPTURE && run && tick && a_match) |=> INT_A)
        else $error("compare A match gave no interrupt");
    match_p_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (run && tick && p_match) |=> (INT_P && (cnt_reg == CNT_ZERO
        || $past(CLEAR_ON_A && (mode == MODE_COMPARE || mode == MODE_TIMER)))))
        else $error("compare P match did not pulse and clear");
    start_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(TIMER_ON) |=> (cnt_reg == CNT_ZERO) ##1 (WAVE_OUT == $past(INIT_LEVEL, 2)))
        else $error("timer start did not clear counter and pin");
    sysclk_count_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (CLK_SEL == CK_SYS && run && !clear_now) |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
        else $error("system clock source did not count");
    low_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_WR && REG_SEL == SEL_A_LO && !(mode == MODE_CAPTURE && capture_now))
        |=> (compare_a_value == $past(compare_a_value) && buffer_reg == $past(REG_WDATA)))
        else $error("low byte write reached the comparator");
    high_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        hi_write_a_s |=> compare_a_value == {$past(REG_WDATA[1:0]), $past(buffer_reg)})
        else $error("high byte write did not merge buffer");
    high_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (hi_read_cnt_s and !REG_WR) |=> buffer_reg == $past(cnt_reg[7:0]))
        else $error("high byte read did not latch low byte");
    low_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_RD && REG_SEL == SEL_CNT_LO) |=> REG_RDATA == $past(buffer_reg))
        else $error("low byte read bypassed the buffer");
    pin_pair_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        WAVE_OUT_INV != WAVE_OUT)
        else $error("output pins not complementary");
    toggle_pin_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (mode == MODE_COMPARE && PIN_ACTION == ACT_TOGGLE && run && tick && a_match)
        |=> ##1 WAVE_OUT != $past(WAVE_OUT))
        else $error("toggle action did not flip pin");
endmodule : timer_unit
